// ### hdl/ancfg_map.svh
`ifndef ANCFG_MAP_SVH
`define ANCFG_MAP_SVH
// ****************************************
// Register offsets.
// ****************************************
`define ANC_A_CTL   5'h00
`define ANC_A_BSR   5'h01
`define ANC_A_ADV   5'h04
`define ANC_A_LPA   5'h05
`define ANC_A_EXP   5'h06
`define ANC_A_STS   5'h10
// ****************************************
// Control fields.
// ****************************************
`define ANC_C_SPD   13
`define ANC_C_ANEN  12
`define ANC_C_RST   9
`define ANC_C_DUP   8
// ****************************************
// Ability word fields.
// ****************************************
`define ANC_W_100F  8
`define ANC_W_100H  7
`define ANC_W_10F   6
`define ANC_W_10H   5
`define ANC_W_RF    13
`define ANC_W_NP    15
`define ANC_SEL     5'h01
`define ANC_BSR_FIX 16'h7849
`define ANC_PD100   16'h0081
`define ANC_PD10    16'h0021
// ****************************************
// Timing.
// ****************************************
`define ANC_BREAK_MS 1500
`define ANC_CLK_KHZ  40000
`define ANC_TW       26
`define ANC_BOOT_N   2'h3
`endif

// ### hdl/ancfg_pkg.sv
`include "ancfg_map.svh"
package ancfg_pkg;
    typedef enum logic [2:0] {
        ST_BOOT, ST_FORCED, ST_BREAK, ST_DETECT, ST_LINK
    } ancfg_st_t;
    typedef struct packed {
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } ancfg_bus_t;
    typedef struct packed {
        logic [15:0] rdata;
        logic        flp_en;
        logic [15:0] tx_word;
        logic        spd100;
        logic        full_dup;
        logic        link_up;
        logic        an_done;
    } ancfg_out_t;
    typedef struct packed {
        ancfg_st_t        st;
        logic [1:0]       boot;
        logic [2:0]       strap_m;
        logic [2:0]       strap_s;
        logic [15:0]      ctl;
        logic [15:0]      adv;
        logic [15:0]      lpa;
        logic             armed;
        logic             pdf;
        logic             page_rx;
        logic             lp_an;
        logic [`ANC_TW-1:0] tmr;
        ancfg_out_t       o;
    } ancfg_state_t;
endpackage : ancfg_pkg

// ### hdl/ancfg_core.sv
// Functional notes
// - Four modes supported, 10/100 half/full; negotiation picks best common one.
// - Negotiation set by registers or three straps: enable and two selects.
// - Straps load advertisement bits 8 down to 5 at reset.
// - Control register writes override strap setting after boot; after a forced strap, enabling needs a prior write with enable clear.
// - Enable strap low: selects force 10H, 10F, 100H, 100F.
// - Enable strap high: selects advertise 10 both, 100 both, halves, all.
// - While enabled, advertisement register is sent in pulse bursts.
// - Rank 100 full, 100 half, 10 full, 10 half.
// - Control register enables, disables and restarts negotiation.
// - Negotiation off: speed and duplex bits set mode; otherwise ignored.
// - Status summary register shows link speed once link is up.
// - Status ability bits fixed one; T4 bit reads zero.
// - Status shows complete, remote fault, link valid, preamble suppression.
// - Advertise all by default; cleared bits drop abilities.
// - Partner register captures base and next-page code words.
// - Parallel detect loads partner register with 0081h or 0021h.
// - Expansion shows detect fault, partner/local next page, page, partner able.
// - Restart bit halts pulses for break-link timer, then resumes bursts.
//
// Implementation choice: the address-and-strobe port.
`include "ancfg_map.svh"
`timescale 1ns/1ps
`default_nettype none
module ancfg_core #(
    parameter int BREAK_CYC = `ANC_BREAK_MS * `ANC_CLK_KHZ
) (
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // Register port.
    input  wire logic [4:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    // Strap pins: enable, select high, select low.
    input  wire logic [2:0]  i_strap,
    // Link side.
    input  wire logic        i_word_valid,
    input  wire logic [15:0] i_word,
    input  wire logic        i_pd_link100,
    input  wire logic        i_pd_link10,
    input  wire logic        i_link_good,
    output logic             o_flp_en,
    output logic      [15:0] o_tx_word,
    output logic             o_spd100,
    output logic             o_full_dup,
    output logic             o_link_up,
    output logic             o_an_done
);
    initial begin
        if (BREAK_CYC < 1 || BREAK_CYC >= (1 << `ANC_TW))
            $error("BREAK_CYC out of range.");
    end

    // ****************************************
    // Decoding functions.
    // ****************************************
    function automatic logic [3:0] strap_adv(input logic [2:0] s);
        logic [3:0] a;
        a = 4'hf;
        if (s[2]) begin
            case (s[1:0])
                2'h0:    a = 4'h3;
                2'h1:    a = 4'hc;
                2'h2:    a = 4'h5;
                default: a = 4'hf;
            endcase
        end
        return a;
    endfunction : strap_adv

    // Returns {found, speed100, full} for the best common mode.
    function automatic logic [2:0] resolve(input logic [15:0] a,
                                           input logic [15:0] b);
        logic [15:0] m;
        m = a & b;
        if (m[`ANC_W_100F])     return 3'h7;
        else if (m[`ANC_W_100H]) return 3'h6;
        else if (m[`ANC_W_10F])  return 3'h5;
        else if (m[`ANC_W_10H])  return 3'h4;
        return 3'h0;
    endfunction : resolve

    // ****************************************
    // State.
    // ****************************************
    ancfg_pkg::ancfg_state_t r, n;
    logic [2:0] res;
    logic       an_on;
    logic       ctl_wr;
    logic [15:0] bsr, expn, sts;

    assign an_on  = r.ctl[`ANC_C_ANEN] & r.armed;
    assign ctl_wr = i_wr && i_addr == `ANC_A_CTL;
    assign res    = resolve(r.adv, i_word);

    // ****************************************
    // Status words.
    // ****************************************
    always_comb begin
        bsr = `ANC_BSR_FIX;
        bsr[5] = r.o.an_done;
        bsr[4] = r.lpa[`ANC_W_RF];
        bsr[2] = r.o.link_up;
        expn = {11'h000, r.pdf, r.lpa[`ANC_W_NP], 1'b0, r.page_rx,
                r.lp_an};
        sts = {11'h000, r.o.an_done, 1'b0, r.o.full_dup, !r.o.spd100,
               r.o.link_up};
    end

    // ****************************************
    // Next state.
    // ****************************************
    always_comb begin
        n = r;
        n.strap_m = i_strap;
        n.strap_s = r.strap_m;
        n.ctl[`ANC_C_RST] = 1'b0;
        n.o.rdata = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                `ANC_A_CTL: begin
                    n.o.rdata = r.ctl;
                    n.o.rdata[`ANC_C_RST] = 1'b0;
                end
                `ANC_A_BSR: n.o.rdata = bsr;
                `ANC_A_ADV: n.o.rdata = r.adv;
                `ANC_A_LPA: n.o.rdata = r.lpa;
                `ANC_A_EXP: n.o.rdata = expn;
                `ANC_A_STS: n.o.rdata = sts;
                default:    n.o.rdata = 16'h0000;
            endcase
            if (i_addr == `ANC_A_EXP)
                n.page_rx = 1'b0;
        end
        if (r.st != ancfg_pkg::ST_BOOT) begin
            if (ctl_wr) begin
                n.ctl = i_wdata & 16'h3300;
                if (!i_wdata[`ANC_C_ANEN])
                    n.armed = 1'b1;
            end
            if (i_wr && i_addr == `ANC_A_ADV)
                n.adv = {7'h00, i_wdata[8:5], `ANC_SEL};
        end
        case (r.st)
            ancfg_pkg::ST_BOOT: begin
                n.boot = r.boot + 2'h1;
                if (r.boot == `ANC_BOOT_N) begin
                    n.adv[8:5] = strap_adv(r.strap_s);
                    n.ctl[`ANC_C_ANEN] = r.strap_s[2];
                    n.ctl[`ANC_C_SPD] = r.strap_s[1];
                    n.ctl[`ANC_C_DUP] = r.strap_s[0];
                    n.armed = r.strap_s[2];
                    n.st = r.strap_s[2] ? ancfg_pkg::ST_DETECT
                                        : ancfg_pkg::ST_FORCED;
                end
            end
            ancfg_pkg::ST_FORCED: begin
                if (an_on)
                    n.st = ancfg_pkg::ST_DETECT;
            end
            ancfg_pkg::ST_BREAK: begin
                n.tmr = r.tmr + `ANC_TW'(1);
                if (r.tmr == `ANC_TW'(BREAK_CYC - 1))
                    n.st = ancfg_pkg::ST_DETECT;
            end
            ancfg_pkg::ST_DETECT: begin
                if (i_word_valid) begin
                    if (res[2]) begin
                        n.st = ancfg_pkg::ST_LINK;
                        n.o.spd100 = res[1];
                        n.o.full_dup = res[0];
                    end
                end else if (i_pd_link100 ^ i_pd_link10) begin
                    n.lpa = i_pd_link100 ? `ANC_PD100 : `ANC_PD10;
                    n.lp_an = 1'b0;
                    n.o.spd100 = i_pd_link100;
                    n.o.full_dup = 1'b0;
                    n.st = ancfg_pkg::ST_LINK;
                end else if (i_pd_link100 && i_pd_link10) begin
                    n.pdf = 1'b1;
                end
            end
            ancfg_pkg::ST_LINK: begin
                if (!i_link_good)
                    n.st = ancfg_pkg::ST_DETECT;
            end
            default: n.st = ancfg_pkg::ST_BOOT;
        endcase
        if ((r.st == ancfg_pkg::ST_DETECT || r.st == ancfg_pkg::ST_LINK)
            && i_word_valid) begin
            n.lpa = i_word;
            n.lp_an = 1'b1;
            n.page_rx = 1'b1;
        end
        if (r.st != ancfg_pkg::ST_BOOT) begin
            if (!an_on) begin
                n.st = ancfg_pkg::ST_FORCED;
                n.o.spd100 = r.ctl[`ANC_C_SPD];
                n.o.full_dup = r.ctl[`ANC_C_DUP];
            end else if (ctl_wr && i_wdata[`ANC_C_RST]
                         && i_wdata[`ANC_C_ANEN]) begin
                n.st = ancfg_pkg::ST_BREAK;
                n.tmr = '0;
            end
        end
        n.o.an_done = n.st == ancfg_pkg::ST_LINK;
        n.o.link_up = n.st == ancfg_pkg::ST_LINK
                      || (n.st == ancfg_pkg::ST_FORCED && i_link_good);
        n.o.flp_en = n.st == ancfg_pkg::ST_DETECT;
        n.o.tx_word = n.adv;
    end

    // ****************************************
    // Registers.
    // ****************************************
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r <= '0;
            r.st <= ancfg_pkg::ST_BOOT;
            r.adv <= {7'h00, 4'hf, `ANC_SEL};
            r.o.tx_word <= {7'h00, 4'hf, `ANC_SEL};
        end else begin
            r <= n;
        end
    end

    // ****************************************
    // Outputs.
    // ****************************************
    assign o_rdata    = r.o.rdata;
    assign o_flp_en   = r.o.flp_en;
    assign o_tx_word  = r.o.tx_word;
    assign o_spd100   = r.o.spd100;
    assign o_full_dup = r.o.full_dup;
    assign o_link_up  = r.o.link_up;
    assign o_an_done  = r.o.an_done;

    // ****************************************
    // Checks.
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    property p_strap;
        r.st == ancfg_pkg::ST_BOOT && r.boot == `ANC_BOOT_N
        |=> r.adv[8:5] == strap_adv($past(r.strap_s));
    endproperty
    a_strap: assert property (p_strap) else $error("strap load wrong");

    property p_restart;
        r.st != ancfg_pkg::ST_BOOT && an_on && ctl_wr
        && i_wdata[`ANC_C_RST] && i_wdata[`ANC_C_ANEN]
        |=> !o_flp_en [*2];
    endproperty
    a_restart: assert property (p_restart) else $error("pulses not halted");

    property p_pd;
        r.st == ancfg_pkg::ST_DETECT && an_on && !ctl_wr && !i_word_valid
        && i_pd_link100 && !i_pd_link10
        |=> r.lpa == `ANC_PD100 && o_spd100 && o_an_done;
    endproperty
    a_pd: assert property (p_pd) else $error("parallel detect wrong");

    property p_rank;
        r.st == ancfg_pkg::ST_DETECT && an_on && !ctl_wr && i_word_valid
        && i_word[`ANC_W_100F] && r.adv[`ANC_W_100F]
        |=> o_spd100 && o_full_dup && o_link_up;
    endproperty
    a_rank: assert property (p_rank) else $error("priority wrong");

    property p_forced;
        r.st != ancfg_pkg::ST_BOOT && !an_on
        |=> o_spd100 == $past(r.ctl[`ANC_C_SPD]) && !o_flp_en;
    endproperty
    a_forced: assert property (p_forced) else $error("forced mode wrong");

    property p_bsr;
        i_rd && i_addr == `ANC_A_BSR
        |=> o_rdata[15:11] == 5'h0f && o_rdata[3] && o_rdata[0];
    endproperty
    a_bsr: assert property (p_bsr) else $error("ability bits wrong");

    property p_sts;
        i_rd && i_addr == `ANC_A_STS
        |=> o_rdata[1] == !$past(o_spd100) && o_rdata[0] == $past(o_link_up);
    endproperty
    a_sts: assert property (p_sts) else $error("summary wrong");

    property p_tx;
        r.st != ancfg_pkg::ST_BOOT && i_wr && i_addr == `ANC_A_ADV
        |=> o_tx_word[`ANC_W_100F:`ANC_W_10H] == $past(i_wdata[`ANC_W_100F:`ANC_W_10H]);
    endproperty
    a_tx: assert property (p_tx) else $error("sent word wrong");

    property p_arm;
        !r.armed |-> r.st != ancfg_pkg::ST_DETECT && !o_an_done;
    endproperty
    a_arm: assert property (p_arm) else $error("unarmed negotiation");

    property p_ctl_wr;
        r.st != ancfg_pkg::ST_BOOT && ctl_wr
        |=> r.ctl[`ANC_C_ANEN] == $past(i_wdata[`ANC_C_ANEN])
            && r.ctl[`ANC_C_SPD] == $past(i_wdata[`ANC_C_SPD])
            && r.ctl[`ANC_C_DUP] == $past(i_wdata[`ANC_C_DUP]);
    endproperty
    a_ctl_wr: assert property (p_ctl_wr) else $error("control write lost");

    property p_rst_rd;
        i_rd && i_addr == `ANC_A_CTL |=> !o_rdata[`ANC_C_RST];
    endproperty
    a_rst_rd: assert property (p_rst_rd) else $error("restart bit read back");

    property p_rst_clr;
        r.ctl[`ANC_C_RST] && !ctl_wr |=> !r.ctl[`ANC_C_RST];
    endproperty
    a_rst_clr: assert property (p_rst_clr) else $error("restart bit stuck");

    property p_lpa;
        (r.st == ancfg_pkg::ST_DETECT || r.st == ancfg_pkg::ST_LINK) && i_word_valid
        |=> r.lpa == $past(i_word) && r.lp_an && r.page_rx;
    endproperty
    a_lpa: assert property (p_lpa) else $error("partner word not taken");

    property p_page;
        i_rd && i_addr == `ANC_A_EXP
        && !((r.st == ancfg_pkg::ST_DETECT || r.st == ancfg_pkg::ST_LINK) && i_word_valid)
        |=> !r.page_rx;
    endproperty
    a_page: assert property (p_page) else $error("page flag not cleared");

    property p_pdf;
        r.st == ancfg_pkg::ST_DETECT && !i_word_valid
        && i_pd_link100 && i_pd_link10
        |=> r.pdf;
    endproperty
    a_pdf: assert property (p_pdf) else $error("detect fault not set");

    property p_pdf_hold;
        r.pdf |=> r.pdf;
    endproperty
    a_pdf_hold: assert property (p_pdf_hold) else $error("detect fault lost");

    property p_pd10;
        r.st == ancfg_pkg::ST_DETECT && an_on && !ctl_wr && !i_word_valid
        && !i_pd_link100 && i_pd_link10
        |=> r.lpa == `ANC_PD10 && !o_spd100 && !o_full_dup && !r.lp_an;
    endproperty
    a_pd10: assert property (p_pd10) else $error("slow parallel detect wrong");

    property p_resume;
        r.st == ancfg_pkg::ST_BREAK && an_on && !ctl_wr
        && r.tmr == `ANC_TW'(BREAK_CYC - 1)
        |=> o_flp_en;
    endproperty
    a_resume: assert property (p_resume) else $error("pulses not resumed");

    property p_loss;
        r.st == ancfg_pkg::ST_LINK && an_on && !ctl_wr && !i_link_good
        |=> o_flp_en && !o_link_up;
    endproperty
    a_loss: assert property (p_loss) else $error("link loss not handled");

    property p_none;
        r.st == ancfg_pkg::ST_DETECT && an_on && !ctl_wr && i_word_valid
        && (r.adv[`ANC_W_100F:`ANC_W_10H] & i_word[`ANC_W_100F:`ANC_W_10H]) == 4'h0
        |=> o_flp_en && !o_an_done;
    endproperty
    a_none: assert property (p_none) else $error("link without common mode");

    property p_bsr_st;
        i_rd && i_addr == `ANC_A_BSR
        |=> o_rdata[5] == $past(o_an_done) && o_rdata[2] == $past(o_link_up);
    endproperty
    a_bsr_st: assert property (p_bsr_st) else $error("status bits wrong");

    property p_sts_dup;
        i_rd && i_addr == `ANC_A_STS
        |=> o_rdata[2] == $past(o_full_dup) && o_rdata[4] == $past(o_an_done);
    endproperty
    a_sts_dup: assert property (p_sts_dup) else $error("summary duplex wrong");
endmodule : ancfg_core
`default_nettype wire

// ### bench/ancfg_lp_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Link partner: sends code words once bursts run, or after waiting 200 cycles without them.
// ****************************************
module ancfg_lp_model (
    // Clock and device side.
    input  wire logic        i_clk,
    input  wire logic        i_flp_en,
    // Partner signals.
    output logic             o_word_valid,
    output logic      [15:0] o_word,
    output logic             o_pd100,
    output logic             o_pd10,
    output logic             o_link_good
);
    initial begin
        o_word_valid = 1'b0;
        o_word       = 16'h0000;
        o_pd100      = 1'b0;
        o_pd10       = 1'b0;
        o_link_good  = 1'b0;
    end
    task automatic send(input logic [15:0] w);
        int n;
        n = 0;
        while (i_flp_en !== 1'b1 && n < 200) begin
            @(posedge i_clk);
            n++;
        end
        @(posedge i_clk);
        o_word       <= w;
        o_word_valid <= 1'b1;
        o_link_good  <= 1'b1;
        @(posedge i_clk);
        o_word_valid <= 1'b0;
        o_word       <= ~w;
    endtask : send
    task automatic set_pd(input logic a, input logic b);
        @(posedge i_clk);
        o_pd100     <= a;
        o_pd10      <= b;
        o_link_good <= a ^ b;
    endtask : set_pd
endmodule : ancfg_lp_model
`default_nettype wire

// ### bench/ancfg_tb_top.sv
`include "ancfg_map.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module ancfg_tb_top;
    logic        i_clk, i_resetn, i_wr, i_rd, wv, pd100, pd10, lg;
    logic [4:0]  i_addr;
    logic [15:0] i_wdata, o_rdata, o_tx_word, wd;
    logic [2:0]  i_strap;
    logic        o_flp_en, o_spd100, o_full_dup, o_link_up, o_an_done;
    int          err_count = 0;
    int          compares  = 0;
    logic [15:0] adv_tab [4] = '{16'h0061, 16'h0181, 16'h00a1, 16'h01e1};
    ancfg_core #(.BREAK_CYC(20)) dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_strap(i_strap),
        .i_word_valid(wv), .i_word(wd), .i_pd_link100(pd100), .i_pd_link10(pd10),
        .i_link_good(lg), .o_flp_en(o_flp_en), .o_tx_word(o_tx_word), .o_spd100(o_spd100),
        .o_full_dup(o_full_dup), .o_link_up(o_link_up), .o_an_done(o_an_done));
    ancfg_lp_model lp (.i_clk(i_clk), .i_flp_en(o_flp_en), .o_word_valid(wv), .o_word(wd),
        .o_pd100(pd100), .o_pd10(pd10), .o_link_good(lg));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic stop_test();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    task automatic boot(input logic [2:0] s);
        @(posedge i_clk);
        i_resetn <= 1'b0;
        i_strap  <= s;
        repeat (10) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (8) @(posedge i_clk);
        #1;
    endtask : boot
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rchk(input logic [4:0] a, input logic [15:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        `CHK("rdata", e, o_rdata)
    endtask : rchk
    task automatic wait_flp();
        int n;
        n = 0;
        while (o_flp_en !== 1'b1 && n < 200) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        `CHK("flp_en", 1'b1, o_flp_en)
    endtask : wait_flp
    task automatic settle();
        repeat (3) @(posedge i_clk);
        #1;
    endtask : settle
    initial begin
        i_resetn = 1'b0;
        i_strap  = 3'h7;
        i_addr   = 5'h00;
        i_wdata  = 16'h0000;
        i_wr     = 1'b0;
        i_rd     = 1'b0;
        for (int i = 0; i < 4; i++) begin
            boot({1'b0, i[1:0]});
            `CHK("forced", i[1:0], {o_spd100, o_full_dup})
            boot({1'b1, i[1:0]});
            rchk(`ANC_A_ADV, adv_tab[i]);
        end
        boot(3'h3);
        wr(`ANC_A_CTL, 16'h1200);
        settle();
        `CHK("flp_en", 1'b0, o_flp_en)
        wr(`ANC_A_CTL, 16'h0000);
        wr(`ANC_A_CTL, 16'h1200);
        wait_flp();
        boot(3'h7);
        rchk(`ANC_A_BSR, 16'h7849);
        rchk(5'h1f, 16'h0000);
        wait_flp();
        `CHK("tx_word", 16'h01e1, o_tx_word)
        lp.send(16'h00c1);
        settle();
        `CHK("mode", 4'hb, {o_spd100, o_full_dup, o_link_up, o_an_done})
        rchk(`ANC_A_LPA, 16'h00c1);
        rchk(`ANC_A_STS, 16'h0011);
        rchk(`ANC_A_BSR, 16'h786d);
        wr(`ANC_A_ADV, 16'h0061);
        wr(`ANC_A_CTL, 16'h1200);
        `CHK("flp_en", 1'b0, o_flp_en)
        wait_flp();
        `CHK("tx_word", 16'h0061, o_tx_word)
        lp.send(16'h01e1);
        settle();
        `CHK("mode", 4'h7, {o_spd100, o_full_dup, o_link_up, o_an_done})
        rchk(`ANC_A_STS, 16'h0017);
        wr(`ANC_A_ADV, 16'h01e1);
        wr(`ANC_A_CTL, 16'h1200);
        wait_flp();
        lp.send(16'h0001);
        settle();
        `CHK("an_done", 1'b0, o_an_done)
        lp.set_pd(1'b1, 1'b1);
        settle();
        rchk(`ANC_A_EXP, 16'h0013);
        lp.set_pd(1'b1, 1'b0);
        settle();
        rchk(`ANC_A_LPA, 16'h0081);
        `CHK("spd100", 1'b1, o_spd100)
        lp.set_pd(1'b0, 1'b0);
        settle();
        `CHK("link_up", 1'b0, o_link_up)
        wr(`ANC_A_CTL, 16'h1200);
        wait_flp();
        lp.set_pd(1'b0, 1'b1);
        settle();
        rchk(`ANC_A_LPA, 16'h0021);
        wr(`ANC_A_CTL, 16'h2100);
        settle();
        `CHK("forced", 3'h7, {o_spd100, o_full_dup, o_link_up})
        rchk(`ANC_A_CTL, 16'h2100);
        wr(`ANC_A_CTL, 16'h0000);
        settle();
        `CHK("forced", 2'h0, {o_spd100, o_full_dup})
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        stop_test();
    end
endmodule : ancfg_tb_top
`default_nettype wire
